// ### src/swdt_pkg.sv
// constants and types shared by the system watchdog timer
package swdt_pkg;

    // ********************************
    // register byte offsets
    // ********************************
    localparam logic [7:0] OFF_WD_CTRL    = 8'h00; // watchdog_control
    localparam logic [7:0] OFF_CLK_CTRL   = 8'h04; // clock_control
    localparam logic [7:0] OFF_IRQ_ENABLE = 8'h08; // extended / global irq enables
    localparam logic [7:0] OFF_IRQ_STATUS = 8'h0c; // sticky events, write one to clear
    localparam logic [7:0] OFF_IRQ_MASK   = 8'h10; // event mask
    localparam logic [7:0] OFF_TIMED_ACC  = 8'h14; // timed access key register

    // ********************************
    // field positions
    // ********************************
    localparam int WDC_RESTART_BIT   = 0; // wd_restart
    localparam int WDC_RST_EN_BIT    = 1; // wd_reset_enable
    localparam int WDC_CAUSE_BIT     = 2; // wd_reset_cause_flag
    localparam int WDC_TIMEOUT_BIT   = 3; // wd_timeout_flag
    localparam int CKC_SEL_LO_BIT    = 6; // wd_interval_sel_lo
    localparam int CKC_SEL_HI_BIT    = 7; // wd_interval_sel_hi
    localparam int IEN_WD_BIT        = 4; // watchdog bit of extended_irq_enable
    localparam int IEN_GLOBAL_BIT    = 7; // global_irq_enable
    localparam int EVT_TIMEOUT_BIT   = 0;
    localparam int EVT_WD_RESET_BIT  = 1;

    // ********************************
    // reset values
    // ********************************
    localparam logic [1:0] RST_INTERVAL_SEL = 2'h0; // shortest interval
    localparam logic [1:0] RST_IRQ_MASK     = 2'h0;

    // ********************************
    // timing and keys
    // ********************************
    localparam logic [7:0] TA_KEY_FIRST     = 8'haa;
    localparam logic [7:0] TA_KEY_SECOND    = 8'h55;
    localparam int         TA_WINDOW_CLKS   = 8;   // clocks a key stage stays open
    localparam int         POST_TIMEOUT_CLKS = 512; // grace period before reset
    localparam int         MACHINE_CYCLE_CLKS = 4;
    localparam int         WD_RST_CLKS      = 2 * MACHINE_CYCLE_CLKS;

    // timed access sequencer states
    typedef enum logic [1:0] {
        SWDT_TA_IDLE = 2'b00,
        SWDT_TA_KEY1 = 2'b01,
        SWDT_TA_OPEN = 2'b10
    } swdt_ta_t;

endpackage

// ### src/swdt_top.sv
// system watchdog timer with apb register access
`timescale 1ns/10ps

// Summary of operation
// (RQ1) count clocks to selected power-of-two interval
// (RQ2) interval end sets timeout flag
// (RQ3) reset 512 clocks later unless restarted
// (RQ4) reset lasts two machine cycles, sets cause
// (RQ5) restart bit clears counter, self clears
// (RQ6) irq needs flag, own and global enable; only wd_irq_req does, the irq output is status and mask alone
// (RQ7) interrupt and reset paths are independent
// (RQ8) flag sets every interval even when disabled
// (RQ9) power reset disables watchdog reset function
// (RQ10) watchdog reset restarts counting, stays enabled
// (RQ11) timeout flag cleared by software or reset
// (RQ12) cause flag cleared by software, power-fail
// (RQ13) reset enable clear leaves counter running
// (RQ14) software restarts within 512 after timeout
// (RQ15) interval select resets to shortest
// (RQ16) protected bits need timed access sequence
// (RQ17) field positions in control registers
// (RQ18) restart cancels pending post-timeout countdown
module swdt_top import swdt_pkg::*; #(
    parameter int INTERVAL_0 = 131072,
    parameter int INTERVAL_1 = 1048576,
    parameter int INTERVAL_2 = 8388608,
    parameter int INTERVAL_3 = 67108864
) (
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // power-fail reset request, asynchronous
    input  wire logic        power_fail_rst,
    // system outputs
    output logic             wd_sys_reset,
    output logic             wd_irq_req,
    output logic             irq
);

    // ********************************
    // functions
    // ********************************
    // last count value of the interval for a select code, interval length in clocks minus one
    function automatic logic [25:0] interval_last(input logic [1:0] sel);
        int n;
        case (sel)
            2'h0: n = INTERVAL_0;
            2'h1: n = INTERVAL_1;
            2'h2: n = INTERVAL_2;
            default: n = INTERVAL_3;
        endcase
        return 26'(n - 1);
    endfunction

    // ********************************
    // state
    // ********************************
    logic [31:0] prdata_ff;
    logic        pready_ff;
    logic        pslverr_ff;
    logic        pf_sync1_ff;
    logic        pf_sync2_ff;
    swdt_ta_t    ta_state_ff;
    logic [3:0]  ta_cnt_ff;
    logic [25:0] counter_ff;
    logic        post_active_ff;
    logic [9:0]  post_cnt_ff;
    logic [3:0]  rst_cnt_ff;
    logic        wd_sys_reset_ff;
    logic        wd_irq_req_ff;
    logic        irq_ff;
    logic        wd_timeout_flag_ff;
    logic        wd_reset_cause_flag_ff;
    logic        wd_reset_enable_ff;
    logic        wd_restart_ff;
    logic [1:0]  sel_ff;
    logic        ie_wd_ff;
    logic        ie_global_ff;
    logic [1:0]  stat_ff;
    logic [1:0]  mask_ff;

    // ********************************
    // apb decode
    // ********************************
    wire hit_wdc  = (paddr == OFF_WD_CTRL);
    wire hit_ckc  = (paddr == OFF_CLK_CTRL);
    wire hit_ien  = (paddr == OFF_IRQ_ENABLE);
    wire hit_stat = (paddr == OFF_IRQ_STATUS);
    wire hit_mask = (paddr == OFF_IRQ_MASK);
    wire hit_ta   = (paddr == OFF_TIMED_ACC);
    wire mapped   = hit_wdc | hit_ckc | hit_ien | hit_stat | hit_mask | hit_ta;
    wire setup    = psel & ~penable;
    wire wr_acc   = psel & penable & pready_ff & pwrite & mapped;
    wire wr_wdc   = wr_acc & hit_wdc;
    wire wr_ta    = wr_acc & hit_ta;
    wire ta_open  = (ta_state_ff == SWDT_TA_OPEN);
    // (RQ16) protected write gate
    wire prot_wr  = wr_wdc & ta_open;

    // read mux, reserved bits zero
    wire [7:0] rd_wdc = {4'h0, wd_timeout_flag_ff, wd_reset_cause_flag_ff, wd_reset_enable_ff, wd_restart_ff};
    wire [7:0] rd_ckc = {sel_ff, 6'h00};
    wire [7:0] rd_ien = {ie_global_ff, 2'h0, ie_wd_ff, 4'h0};
    wire [7:0] rd_sel = hit_wdc  ? rd_wdc :
                        hit_ckc  ? rd_ckc :
                        hit_ien  ? rd_ien :
                        hit_stat ? {6'h00, stat_ff} :
                        hit_mask ? {6'h00, mask_ff} :
                        hit_ta   ? {7'h00, ta_open} : 8'h00;
    wire [31:0] nxt_prdata  = (setup & ~pwrite) ? {24'h000000, rd_sel} : prdata_ff;
    wire        nxt_pready  = setup;
    wire        nxt_pslverr = setup & ~mapped;

    // apb response registers, no wait states per access
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_ff  <= 32'h00000000;
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
        end else begin
            prdata_ff  <= nxt_prdata;
            pready_ff  <= nxt_pready;
            pslverr_ff <= nxt_pslverr;
        end
    end

    // ********************************
    // power-fail synchroniser
    // ********************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pf_sync1_ff <= 1'b0;
            pf_sync2_ff <= 1'b0;
        end else begin
            pf_sync1_ff <= power_fail_rst;
            pf_sync2_ff <= pf_sync1_ff;
        end
    end
    wire pf_lvl = pf_sync2_ff;

    // ********************************
    // timed access sequencer
    // ********************************
    swdt_ta_t   nxt_ta_state;
    logic [3:0] nxt_ta_cnt;
    wire        ta_expired = (ta_cnt_ff == 4'(TA_WINDOW_CLKS - 1));
    always_comb begin
        nxt_ta_state = ta_state_ff;
        nxt_ta_cnt   = ta_cnt_ff + 4'h1;
        case (ta_state_ff)
            SWDT_TA_IDLE: begin
                nxt_ta_cnt = 4'h0;
                if (wr_ta && pwdata[7:0] == TA_KEY_FIRST) begin
                    nxt_ta_state = SWDT_TA_KEY1;
                end
            end
            SWDT_TA_KEY1: begin
                if (wr_ta && pwdata[7:0] == TA_KEY_SECOND) begin
                    nxt_ta_state = SWDT_TA_OPEN;
                    nxt_ta_cnt   = 4'h0;
                end else if (wr_ta || ta_expired) begin
                    nxt_ta_state = SWDT_TA_IDLE;
                end
            end
            SWDT_TA_OPEN: begin
                if (prot_wr || ta_expired) begin
                    nxt_ta_state = SWDT_TA_IDLE;
                end
            end
            default: nxt_ta_state = SWDT_TA_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ta_state_ff <= SWDT_TA_IDLE;
            ta_cnt_ff   <= 4'h0;
        end else begin
            ta_state_ff <= nxt_ta_state;
            ta_cnt_ff   <= nxt_ta_cnt;
        end
    end

    // ********************************
    // watchdog counter and post-timeout wait
    // ********************************
    wire wd_rst_active = wd_sys_reset_ff;
    // (RQ1) interval compare
    wire timeout_hit = (counter_ff == interval_last(sel_ff)) & ~wd_rst_active;
    wire post_end    = post_active_ff & (post_cnt_ff == 10'(POST_TIMEOUT_CLKS - 1));
    // (RQ3) reset only when enabled
    // (RQ13) enable gates the reset alone
    wire fire        = post_end & wd_reset_enable_ff & ~wd_restart_ff & ~pf_lvl;
    // (RQ5) restart or reset clears count
    wire [25:0] nxt_counter = (wd_restart_ff | wd_rst_active | fire | pf_lvl | timeout_hit) ? 26'h0000000
                                                                                            : counter_ff + 26'h0000001;
    // (RQ18) restart cancels grace period
    wire        nxt_post_active = ~(wd_restart_ff | wd_rst_active | pf_lvl | post_end) &
                                  (timeout_hit | post_active_ff);
    wire [9:0]  nxt_post_cnt    = (timeout_hit | ~post_active_ff) ? 10'h000 : post_cnt_ff + 10'h001;
    // (RQ4) two machine cycle reset
    wire [3:0]  nxt_rst_cnt     = fire ? 4'(WD_RST_CLKS) : (rst_cnt_ff != 4'h0) ? rst_cnt_ff - 4'h1 : 4'h0;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            counter_ff      <= 26'h0000000;
            post_active_ff  <= 1'b0;
            post_cnt_ff     <= 10'h000;
            rst_cnt_ff      <= 4'h0;
            wd_sys_reset_ff <= 1'b0;
        end else begin
            counter_ff      <= nxt_counter;
            post_active_ff  <= nxt_post_active;
            post_cnt_ff     <= nxt_post_cnt;
            rst_cnt_ff      <= nxt_rst_cnt;
            wd_sys_reset_ff <= (nxt_rst_cnt != 4'h0);
        end
    end

    // ********************************
    // control register bits
    // ********************************
    // (RQ2) flag set wins over software clear, (RQ8) regardless of enables
    // (RQ11) any reset clears the flag
    wire nxt_wd_timeout_flag     = (pf_lvl | wd_rst_active) ? 1'b0 :
                                   timeout_hit              ? 1'b1 :
                                   (prot_wr & ~pwdata[WDC_TIMEOUT_BIT]) ? 1'b0 : wd_timeout_flag_ff;
    // (RQ12) cause flag, never set while reset disabled
    wire nxt_wd_reset_cause_flag = pf_lvl ? 1'b0 :
                                   fire   ? 1'b1 :
                                   (wr_wdc & ~pwdata[WDC_CAUSE_BIT]) ? 1'b0 : wd_reset_cause_flag_ff;
    // (RQ9) power-fail disables, (RQ10) watchdog reset keeps enable
    wire nxt_wd_reset_enable     = pf_lvl ? 1'b0 : prot_wr ? pwdata[WDC_RST_EN_BIT] : wd_reset_enable_ff;
    // (RQ5) self-clearing restart
    wire nxt_wd_restart          = prot_wr & pwdata[WDC_RESTART_BIT] & ~pf_lvl;
    // (RQ17) interval select at bits 7:6
    wire [1:0] nxt_sel = (wr_acc & hit_ckc) ? pwdata[CKC_SEL_HI_BIT:CKC_SEL_LO_BIT] : sel_ff;

    // (RQ15) shortest interval after reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wd_timeout_flag_ff     <= 1'b0;
            wd_reset_cause_flag_ff <= 1'b0;
            wd_reset_enable_ff     <= 1'b0;
            wd_restart_ff          <= 1'b0;
            sel_ff                 <= RST_INTERVAL_SEL;
        end else begin
            wd_timeout_flag_ff     <= nxt_wd_timeout_flag;
            wd_reset_cause_flag_ff <= nxt_wd_reset_cause_flag;
            wd_reset_enable_ff     <= nxt_wd_reset_enable;
            wd_restart_ff          <= nxt_wd_restart;
            sel_ff                 <= nxt_sel;
        end
    end

    // ********************************
    // interrupts
    // ********************************
    wire       nxt_ie_wd     = (wr_acc & hit_ien) ? pwdata[IEN_WD_BIT] : ie_wd_ff;
    wire       nxt_ie_global = (wr_acc & hit_ien) ? pwdata[IEN_GLOBAL_BIT] : ie_global_ff;
    wire [1:0] nxt_mask      = (wr_acc & hit_mask) ? pwdata[1:0] : mask_ff;
    wire [1:0] evt_set       = {fire, timeout_hit};
    wire [1:0] stat_clr      = (wr_acc & hit_stat) ? pwdata[1:0] : 2'h0;
    // sticky events, set wins over write-one clear
    wire [1:0] nxt_stat      = evt_set | (stat_ff & ~stat_clr);
    // (RQ6) request needs all three
    // (RQ7) independent of reset path
    wire       nxt_wd_irq    = nxt_wd_timeout_flag & nxt_ie_wd & nxt_ie_global;
    wire       nxt_irq       = |(nxt_stat & nxt_mask);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ie_wd_ff      <= 1'b0;
            ie_global_ff  <= 1'b0;
            mask_ff       <= RST_IRQ_MASK;
            stat_ff       <= 2'h0;
            wd_irq_req_ff <= 1'b0;
            irq_ff        <= 1'b0;
        end else begin
            ie_wd_ff      <= nxt_ie_wd;
            ie_global_ff  <= nxt_ie_global;
            mask_ff       <= nxt_mask;
            stat_ff       <= nxt_stat;
            wd_irq_req_ff <= nxt_wd_irq;
            irq_ff        <= nxt_irq;
        end
    end

    // outputs straight from flops
    assign prdata       = prdata_ff;
    assign pready       = pready_ff;
    assign pslverr      = pslverr_ff;
    assign wd_sys_reset = wd_sys_reset_ff;
    assign wd_irq_req   = wd_irq_req_ff;
    assign irq          = irq_ff;

    // ********************************
    // assertions
    // ********************************
    property p_timeout_flag;
        @(posedge pclk) disable iff (!presetn)
        (timeout_hit && !pf_lvl) |=> wd_timeout_flag_ff && stat_ff[EVT_TIMEOUT_BIT];
    endproperty
    a_timeout_flag: assert property (p_timeout_flag) else $error("timeout did not set flag"); // RQ2

    property p_interval_len;
        @(posedge pclk) disable iff (!presetn)
        (counter_ff != interval_last(sel_ff) && !wd_restart_ff && !wd_rst_active && !fire && !pf_lvl)
            |=> counter_ff == $past(counter_ff) + 26'h0000001;
    endproperty
    a_interval_len: assert property (p_interval_len) else $error("counter skipped a clock"); // RQ1

    property p_reset_after_grace;
        @(posedge pclk) disable iff (!presetn)
        (post_end && wd_reset_enable_ff && !wd_restart_ff && !pf_lvl) |=> wd_sys_reset_ff && wd_reset_cause_flag_ff;
    endproperty
    a_reset_after_grace: assert property (p_reset_after_grace) else $error("no reset after grace"); // RQ3

    property p_reset_length;
        @(posedge pclk) disable iff (!presetn)
        $rose(wd_sys_reset_ff) |-> wd_sys_reset_ff [*8] ##1 !wd_sys_reset_ff;
    endproperty
    a_reset_length: assert property (p_reset_length) else $error("reset length wrong"); // RQ4

    property p_restart_clears;
        @(posedge pclk) disable iff (!presetn)
        wd_restart_ff |=> counter_ff == 26'h0000000 && !post_active_ff && !wd_restart_ff;
    endproperty
    a_restart_clears: assert property (p_restart_clears) else $error("restart did not clear"); // RQ5

    property p_irq_req;
        @(posedge pclk) disable iff (!presetn)
        wd_irq_req_ff |-> wd_timeout_flag_ff && ie_wd_ff && ie_global_ff;
    endproperty
    a_irq_req: assert property (p_irq_req) else $error("irq without all enables"); // RQ6

    property p_no_reset_disabled;
        @(posedge pclk) disable iff (!presetn)
        (post_end && !wd_reset_enable_ff) |=> !$rose(wd_sys_reset_ff) && $stable(wd_reset_cause_flag_ff) ||
                                              $fell(wd_reset_cause_flag_ff);
    endproperty
    a_no_reset_disabled: assert property (p_no_reset_disabled) else $error("reset while disabled"); // RQ13

    property p_pf_disables;
        @(posedge pclk) disable iff (!presetn)
        pf_lvl |=> !wd_reset_enable_ff && !wd_reset_cause_flag_ff && !wd_timeout_flag_ff;
    endproperty
    a_pf_disables: assert property (p_pf_disables) else $error("power-fail left watchdog on"); // RQ9

    property p_unprotected_ignored;
        @(posedge pclk) disable iff (!presetn)
        (wr_wdc && !ta_open && !pf_lvl) |=> $stable(wd_reset_enable_ff) && !wd_restart_ff;
    endproperty
    a_unprotected_ignored: assert property (p_unprotected_ignored) else $error("unprotected write took"); // RQ16

    property p_wd_reset_keeps_enable;
        @(posedge pclk) disable iff (!presetn)
        (wd_sys_reset_ff && !pf_lvl && !prot_wr) |=> $stable(wd_reset_enable_ff) && counter_ff == 26'h0000000;
    endproperty
    a_wd_reset_keeps_enable: assert property (p_wd_reset_keeps_enable) else $error("wd reset lost enable"); // RQ10

endmodule

// ### verification/test_system_watchdog_timer.sv
// self-checking bench for the system watchdog timer
`timescale 1ns/10ps
module test_system_watchdog_timer import swdt_pkg::*; ;

    // ********************************
    // signals and rows
    // ********************************
    typedef struct {logic [1:0] sel; int clks;} swdt_row_t;
    typedef struct {logic [7:0] addr; logic [7:0] val; logic err;} swdt_rd_t;

    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        power_fail_rst = 1'b0;
    logic        wd_sys_reset;
    logic        wd_irq_req;
    logic        irq;
    logic [7:0]  rdq;
    logic        rde;
    int          err_total = 0;
    int          compares = 0;
    int          n;
    // interval select beside the clocks to time-out (shortened intervals)
    swdt_row_t   rows [4] = '{'{2'h0, 1024}, '{2'h1, 1536}, '{2'h2, 2048}, '{2'h3, 4096}};
    // reset reads: address, value, slave error (0x18 is unmapped)
    swdt_rd_t    rst_rows [7] = '{'{OFF_WD_CTRL, 8'h00, 1'b0}, '{OFF_CLK_CTRL, {RST_INTERVAL_SEL, 6'h0}, 1'b0},
                                  '{OFF_IRQ_ENABLE, 8'h00, 1'b0}, '{OFF_IRQ_STATUS, 8'h00, 1'b0},
                                  '{OFF_IRQ_MASK, 8'h00, 1'b0}, '{OFF_TIMED_ACC, 8'h00, 1'b0}, '{8'h18, 8'h00, 1'b1}};

    // clock of 100 ns
    always #50 pclk = ~pclk;

    swdt_top #(
        .INTERVAL_0 (1024),
        .INTERVAL_1 (1536),
        .INTERVAL_2 (2048),
        .INTERVAL_3 (4096)
    ) dut (
        .pclk           (pclk),
        .presetn        (presetn),
        .psel           (psel),
        .penable        (penable),
        .pwrite         (pwrite),
        .paddr          (paddr),
        .pwdata         (pwdata),
        .prdata         (prdata),
        .pready         (pready),
        .pslverr        (pslverr),
        .power_fail_rst (power_fail_rst),
        .wd_sys_reset   (wd_sys_reset),
        .wd_irq_req     (wd_irq_req),
        .irq            (irq)
    );

    // ********************************
    // tasks
    // ********************************
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    // pass when the count lies within tol of the expected figure
    task automatic near(input string what, input int exp, input int got, input int tol);
        chk(what, exp, (got >= exp - tol && got <= exp + tol) ? exp : got);
    endtask

    // one apb transfer; two idle edges after it let registered outputs settle
    task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d);
        int w;
        w = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && w < 16) begin
            @(posedge pclk);
            w++;
        end
        if (w == 16) chk("pready", 32'h1, 32'h0);
        rdq = prdata[7:0];
        rde = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        repeat (2) @(posedge pclk);
    endtask

    // key pair then a protected write of watchdog_control
    task automatic tawr(input logic [7:0] d);
        apb(1'b1, OFF_TIMED_ACC, TA_KEY_FIRST);
        apb(1'b1, OFF_TIMED_ACC, TA_KEY_SECOND);
        apb(1'b1, OFF_WD_CTRL, d);
    endtask

    // clocks until request (0), system reset (1) or irq (2) is high, bounded
    task automatic waitfor(input int which, input int lim, output int c);
        c = 0;
        while (c < lim && (which == 0 ? wd_irq_req : (which == 1 ? wd_sys_reset : irq)) !== 1'b1) begin
            @(posedge pclk);
            c++;
        end
    endtask

    // clocks with the system reset high over a span
    task automatic highs(input int span, output int c);
        c = 0;
        repeat (span) begin
            @(posedge pclk);
            if (wd_sys_reset === 1'b1) c++;
        end
    endtask

    task automatic rd_wd(input string what, input logic [7:0] exp);
        apb(1'b0, OFF_WD_CTRL, 8'h00);
        chk(what, {24'h0, exp}, {24'h0, rdq});
    endtask

    task automatic rst_check();
        foreach (rst_rows[i]) begin
            apb(1'b0, rst_rows[i].addr, 8'h00);
            chk("reset read", {24'h0, rst_rows[i].val}, {24'h0, rdq});
            chk("slave error", {31'h0, rst_rows[i].err}, {31'h0, rde});
        end
        chk("outputs", 32'h0, {29'h0, wd_sys_reset, wd_irq_req, irq});
        $display("reset values checked");
    endtask

    task automatic results();
        $display("compares %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // watchdog span: about three times the expected run
    initial begin
        #6000000;
        chk("run time", 32'h0, 32'h1);
        results();
    end

    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rst_check();
        apb(1'b1, OFF_IRQ_ENABLE, 8'h90);
        foreach (rows[i]) begin
            apb(1'b1, OFF_CLK_CTRL, {rows[i].sel, 6'h0});
            apb(1'b0, OFF_CLK_CTRL, 8'h00);
            chk("interval select", {24'h0, rows[i].sel, 6'h0}, {24'h0, rdq});
            tawr(8'h01);
            waitfor(0, 5000, n);
            near("interval clocks", rows[i].clks, n, 4);
            rd_wd("flag set", 8'h08);
            tawr(8'h00);
        end
        $display("interval rows checked");
        // interrupt path with global enable off, then on
        apb(1'b1, OFF_IRQ_ENABLE, 8'h10);
        apb(1'b1, OFF_IRQ_STATUS, 8'h03);
        apb(1'b1, OFF_IRQ_MASK, 8'h01);
        tawr(8'h01);
        waitfor(2, 5000, n);
        near("polled interval", rows[3].clks, n, 4);
        chk("request no global", 32'h0, {31'h0, wd_irq_req});
        apb(1'b1, OFF_WD_CTRL, 8'h00);
        rd_wd("unprotected write", 8'h08);
        apb(1'b1, OFF_IRQ_MASK, 8'h00);
        chk("masked irq", 32'h0, {31'h0, irq});
        apb(1'b1, OFF_IRQ_MASK, 8'h01);
        chk("unmasked irq", 32'h1, {31'h0, irq});
        apb(1'b1, OFF_IRQ_STATUS, 8'h01);
        chk("cleared irq", 32'h0, {31'h0, irq});
        apb(1'b1, OFF_IRQ_ENABLE, 8'h90);
        chk("request global", 32'h1, {31'h0, wd_irq_req});
        tawr(8'h00);
        chk("flag cleared", 32'h0, {31'h0, wd_irq_req});
        $display("interrupt path checked");
        // reset path on the shortest interval
        apb(1'b1, OFF_CLK_CTRL, 8'h00);
        tawr(8'h03);
        rd_wd("reset enable", 8'h02);
        waitfor(0, 1200, n);
        waitfor(1, 1000, n);
        near("grace clocks", POST_TIMEOUT_CLKS, n, 2);
        n = 0;
        while (wd_sys_reset === 1'b1 && n < 50) begin
            @(posedge pclk);
            n++;
        end
        chk("reset length", WD_RST_CLKS, n);
        waitfor(0, 1200, n);
        near("count after reset", rows[0].clks, n, 4);
        rd_wd("cause and enable", 8'h0e);
        apb(1'b0, OFF_IRQ_STATUS, 8'h00);
        chk("status events", 32'h03, {24'h0, rdq});
        $display("reset path checked");
        // power fail during the grace period
        power_fail_rst <= 1'b1;
        repeat (4) @(posedge pclk);
        power_fail_rst <= 1'b0;
        repeat (3) @(posedge pclk);
        rd_wd("power fail", 8'h00);
        highs(1100, n);
        chk("reset disabled", 32'h0, n);
        rd_wd("still counting", 8'h08);
        $display("power fail checked");
        // restart within the grace period
        tawr(8'h03);
        waitfor(0, 1200, n);
        near("timeout before restart", rows[0].clks, n, 4);
        repeat (100) @(posedge pclk);
        tawr(8'h03);
        highs(500, n);
        chk("restart cancels", 32'h0, n);
        $display("restart cancel checked");
        // power-on reset in mid-run
        apb(1'b1, OFF_CLK_CTRL, 8'hc0);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rst_check();
        highs(700, n);
        chk("power on disables", 32'h0, n);
        results();
    end

endmodule
